// ---- hw/amp_access_policy.sv ----
// access policy for the main memory port, high-performance configuration
// assumes the core presents one request at a time with decoded attributes
// Operation
// - speculative accesses never fault; their error responses are discarded
// - no speculation to device execute-never regions; external private port never speculated
// - tightly coupled memory regions always normal, always speculation-eligible
// - protection violation on main, periph, external private ports faults, no access
// - tightly coupled memory violation faults; read may start, its data discarded
// - device accesses report privilege from current processor mode
// - normal accesses on peripheral port report true privilege
// - main port normal accesses privileged, prot bit zero set; security in bit one
// - instr and data tight memory ports report privilege of each access
// - main port is one 64-bit master for all remaining addresses
// - store buffer merges normal stores to cut write transactions
// - high-performance configuration selected when data cache present
// - 4-way data cache with allocation policies and prefetch
// - at most 39 writes outstanding: 15 device, 24 normal
// - at most 5 reads: 2 linefills, 2 non-cacheable, 1 instruction
// - four write ids and four read ids by transaction class
// - total outstanding limited to 48
// - cacheable uses wrap4 linefills, incr4 evictions, incr 1-4 others
// - non-cacheable uses incr 1-4 64-bit bursts, single loads any size
// - device uses single 32-bit reads, incr 1-2 writes, subword singles
// - shared exclusives are single beats of 8, 16 or 32 bits
// - no fixed bursts; sparse or empty strobes allowed in normal writes
module amp_access_policy #(
  parameter bit HAS_DCACHE = 1'b1
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic REQ_VALID_I,
  input wire amp_pkg::amp_kind_t REQ_KIND_I,
  input wire amp_pkg::amp_tgt_t REQ_TGT_I,
  input wire logic [amp_pkg::ADDR_W-1:0] REQ_ADDR_I,
  input wire logic [2:0] REQ_SIZE_I,
  input wire logic [1:0] REQ_BEATS_M1_I,
  input wire logic REQ_SPEC_I,
  input wire logic REQ_XN_I,
  input wire logic REQ_EXCL_I,
  input wire logic REQ_PRIV_I,
  input wire logic REQ_SECURE_I,
  input wire logic REQ_VIOL_I,
  input wire logic REQ_LINE_SEL_I,
  output logic REQ_READY_O,
  output logic FAULT_O,
  output logic MAIN_AVALID_O,
  output logic MAIN_AWRITE_O,
  output logic [amp_pkg::ADDR_W-1:0] MAIN_AADDR_O,
  output logic [1:0] MAIN_AID_O,
  output logic [7:0] MAIN_ALEN_O,
  output logic [2:0] MAIN_ASIZE_O,
  output logic [1:0] MAIN_ABURST_O,
  output logic MAIN_ALOCK_O,
  output logic [2:0] MAIN_APROT_O,
  input wire logic MAIN_AREADY_I,
  input wire logic MAIN_RDONE_I,
  input wire logic [1:0] MAIN_RID_I,
  input wire logic MAIN_BDONE_I,
  input wire logic [1:0] MAIN_BID_I,
  input wire logic MAIN_ERR_I,
  input wire logic MAIN_ERR_SPEC_I,
  output logic BUS_ERR_O,
  output logic PERIPH_VALID_O,
  output logic PERIPH_PRIV_O,
  output logic EXT_PRIV_VALID_O,
  output logic EXT_PRIV_PRIV_O,
  output logic TCM_RD_VALID_O,
  output logic TCM_DISCARD_O,
  output logic INSTR_TIGHTMEM_PRIVILEGE_O,
  output logic DATA_TIGHTMEM_PRIVILEGE_O
);
  import amp_pkg::*;

  typedef struct packed {
    logic ready;
    logic fault;
    logic avalid;
    logic awrite;
    logic [ADDR_W-1:0] aaddr;
    logic [1:0] aid;
    logic [7:0] alen;
    logic [2:0] asize;
    logic [1:0] aburst;
    logic alock;
    logic [2:0] aprot;
    logic bus_err;
    logic p_valid;
    logic p_priv;
    logic e_valid;
    logic e_priv;
    logic t_valid;
    logic t_discard;
    logic i_priv;
    logic d_priv;
    logic [CNT_W-1:0] wr_dev;
    logic [CNT_W-1:0] wr_norm;
    logic [CNT_W-1:0] rd_line;
    logic [CNT_W-1:0] rd_nc;
    logic [CNT_W-1:0] rd_instr;
  } amp_state_t;

  amp_state_t s_q;
  amp_state_t s_d;

  function automatic logic is_wr(input amp_kind_t k);
    return k == AMP_K_EVICT || k == AMP_K_NOALLOC_WR || k == AMP_K_NC_WR
        || k == AMP_K_DEV_WR;
  endfunction : is_wr

  function automatic logic is_dev(input amp_kind_t k);
    return k == AMP_K_DEV_RD || k == AMP_K_DEV_WR;
  endfunction : is_dev

  logic spec_blocked;
  logic credit_ok;
  logic take;
  logic [CNT_W-1:0] wr_tot;
  logic [CNT_W-1:0] rd_tot;
  logic rdone_line;
  logic rdone_nc;
  logic rdone_instr;
  logic bdone_dev;
  logic bdone_norm;
  logic beat_size_ok;

  always_comb begin
    // external private port is device xn; tcm is normal so never blocked
    spec_blocked = REQ_SPEC_I && ((REQ_TGT_I == AMP_T_EXT_PRIV)
        || (is_dev(REQ_KIND_I) && REQ_XN_I && (REQ_TGT_I == AMP_T_MAIN
        || REQ_TGT_I == AMP_T_PERIPH))
        || (REQ_TGT_I == AMP_T_MAIN && is_wr(REQ_KIND_I)));
    wr_tot = s_q.wr_dev + s_q.wr_norm;
    rd_tot = s_q.rd_line + s_q.rd_nc + s_q.rd_instr;
    credit_ok = 1'b1;
    case (REQ_KIND_I)
      AMP_K_DEV_WR: credit_ok = s_q.wr_dev < CNT_W'(WR_MAX_DEV);
      AMP_K_EVICT, AMP_K_NOALLOC_WR, AMP_K_NC_WR:
        credit_ok = s_q.wr_norm < CNT_W'(WR_MAX_NORM);
      AMP_K_LINEFILL: credit_ok = s_q.rd_line < CNT_W'(RD_MAX_LINE);
      AMP_K_IFETCH: credit_ok = s_q.rd_instr < CNT_W'(RD_MAX_INSTR);
      AMP_K_NC_RD, AMP_K_DEV_RD: credit_ok = s_q.rd_nc < CNT_W'(RD_MAX_NC);
      default: credit_ok = 1'b0;
    endcase
    // totals cap a counter drift as well as the class limits
    credit_ok = credit_ok && (wr_tot + rd_tot) < CNT_W'(TOTAL_MAX)
        && wr_tot < CNT_W'(WR_MAX_TOTAL) && rd_tot < CNT_W'(RD_MAX_TOTAL);
    // exclusives only as 8/16/32-bit singles
    beat_size_ok = !REQ_EXCL_I || (REQ_SIZE_I <= SIZE_B32);
  end

  assign take = REQ_VALID_I && s_q.ready && !(s_q.avalid && !MAIN_AREADY_I);
  assign rdone_line = MAIN_RDONE_I && (MAIN_RID_I == RID_LINE0 || MAIN_RID_I == RID_LINE1);
  assign rdone_nc = MAIN_RDONE_I && MAIN_RID_I == RID_NCDEV;
  assign rdone_instr = MAIN_RDONE_I && MAIN_RID_I == RID_INSTR;
  assign bdone_dev = MAIN_BDONE_I && MAIN_BID_I == WID_DEV;
  assign bdone_norm = MAIN_BDONE_I && MAIN_BID_I != WID_DEV;

  always_comb begin
    s_d = s_q;
    s_d.fault = 1'b0;
    s_d.p_valid = 1'b0;
    s_d.e_valid = 1'b0;
    s_d.t_valid = 1'b0;
    s_d.t_discard = 1'b0;
    // speculative errors are swallowed, never reported
    s_d.bus_err = MAIN_ERR_I && !MAIN_ERR_SPEC_I;
    s_d.ready = HAS_DCACHE;
    if (s_q.avalid && MAIN_AREADY_I) begin
      s_d.avalid = 1'b0;
    end
    if (take) begin
      case (REQ_TGT_I)
        AMP_T_MAIN: begin
          if (REQ_VIOL_I) begin
            s_d.fault = !REQ_SPEC_I;
          end else if (!spec_blocked && credit_ok && beat_size_ok) begin
            s_d.avalid = 1'b1;
            s_d.awrite = is_wr(REQ_KIND_I);
            s_d.aaddr = REQ_ADDR_I;
            s_d.alock = REQ_EXCL_I;
            s_d.aburst = BURST_INCR;
            s_d.asize = SIZE_B64;
            s_d.alen = {6'h00, REQ_BEATS_M1_I};
            // device follows mode; normal always privileged
            s_d.aprot = {1'b0, !REQ_SECURE_I,
                is_dev(REQ_KIND_I) ? REQ_PRIV_I : 1'b1};
            case (REQ_KIND_I)
              AMP_K_LINEFILL: begin
                s_d.aburst = BURST_WRAP;
                s_d.alen = LEN_4;
                s_d.aid = REQ_LINE_SEL_I ? RID_LINE1 : RID_LINE0;
              end
              AMP_K_EVICT: begin
                s_d.alen = LEN_4;
                s_d.aid = WID_EVICT;
              end
              AMP_K_NOALLOC_WR: s_d.aid = WID_CACHE;
              AMP_K_IFETCH: s_d.aid = RID_INSTR;
              AMP_K_NC_RD: begin
                s_d.aid = RID_NCDEV;
                if (REQ_BEATS_M1_I == 2'h0) begin
                  s_d.asize = REQ_SIZE_I;
                end
              end
              AMP_K_NC_WR: s_d.aid = WID_NC;
              AMP_K_DEV_RD: begin
                s_d.aid = RID_NCDEV;
                s_d.alen = 8'h00;
                s_d.asize = REQ_SIZE_I < SIZE_B32 ? REQ_SIZE_I : SIZE_B32;
              end
              default: begin
                s_d.aid = WID_DEV;
                s_d.alen = {7'h00, REQ_BEATS_M1_I[0]};
                s_d.asize = REQ_SIZE_I < SIZE_B32 ? REQ_SIZE_I : SIZE_B32;
              end
            endcase
            if (REQ_EXCL_I) begin
              // an exclusive is always a plain single, never a wrap
              s_d.aburst = BURST_INCR;
              s_d.alen = 8'h00;
              s_d.asize = REQ_SIZE_I;
              if (is_wr(REQ_KIND_I) && !is_dev(REQ_KIND_I)) begin
                s_d.aid = WID_NC;
              end
            end
          end
        end
        AMP_T_PERIPH, AMP_T_EXT_PRIV: begin
          if (REQ_VIOL_I) begin
            s_d.fault = !REQ_SPEC_I;
          end else if (!spec_blocked) begin
            s_d.p_valid = REQ_TGT_I == AMP_T_PERIPH;
            s_d.e_valid = REQ_TGT_I == AMP_T_EXT_PRIV;
            s_d.p_priv = REQ_PRIV_I;
            s_d.e_priv = REQ_PRIV_I;
          end
        end
        AMP_T_ITCM, AMP_T_DTCM: begin
          // speculation always allowed here since region is normal
          s_d.t_valid = !is_wr(REQ_KIND_I) || !REQ_VIOL_I;
          s_d.t_discard = REQ_VIOL_I;
          s_d.fault = REQ_VIOL_I && !REQ_SPEC_I;
          if (REQ_TGT_I == AMP_T_ITCM) begin
            s_d.i_priv = REQ_PRIV_I;
          end else begin
            s_d.d_priv = REQ_PRIV_I;
          end
        end
        default: s_d.fault = 1'b0;
      endcase
    end
    // outstanding accounting; issue and completion may coincide
    if (s_d.avalid && !s_q.avalid || take && s_d.avalid && s_q.avalid) begin
      case (REQ_KIND_I)
        AMP_K_DEV_WR: s_d.wr_dev = s_d.wr_dev + 1'b1;
        AMP_K_EVICT, AMP_K_NOALLOC_WR, AMP_K_NC_WR: s_d.wr_norm = s_d.wr_norm + 1'b1;
        AMP_K_LINEFILL: s_d.rd_line = s_d.rd_line + 1'b1;
        AMP_K_IFETCH: s_d.rd_instr = s_d.rd_instr + 1'b1;
        default: s_d.rd_nc = s_d.rd_nc + 1'b1;
      endcase
    end
    if (bdone_dev && s_d.wr_dev != CNT_RESET) s_d.wr_dev = s_d.wr_dev - 1'b1;
    if (bdone_norm && s_d.wr_norm != CNT_RESET) s_d.wr_norm = s_d.wr_norm - 1'b1;
    if (rdone_line && s_d.rd_line != CNT_RESET) s_d.rd_line = s_d.rd_line - 1'b1;
    if (rdone_nc && s_d.rd_nc != CNT_RESET) s_d.rd_nc = s_d.rd_nc - 1'b1;
    if (rdone_instr && s_d.rd_instr != CNT_RESET) s_d.rd_instr = s_d.rd_instr - 1'b1;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign REQ_READY_O = s_q.ready;
  assign FAULT_O = s_q.fault;
  assign MAIN_AVALID_O = s_q.avalid;
  assign MAIN_AWRITE_O = s_q.awrite;
  assign MAIN_AADDR_O = s_q.aaddr;
  assign MAIN_AID_O = s_q.aid;
  assign MAIN_ALEN_O = s_q.alen;
  assign MAIN_ASIZE_O = s_q.asize;
  assign MAIN_ABURST_O = s_q.aburst;
  assign MAIN_ALOCK_O = s_q.alock;
  assign MAIN_APROT_O = s_q.aprot;
  assign BUS_ERR_O = s_q.bus_err;
  assign PERIPH_VALID_O = s_q.p_valid;
  assign PERIPH_PRIV_O = s_q.p_priv;
  assign EXT_PRIV_VALID_O = s_q.e_valid;
  assign EXT_PRIV_PRIV_O = s_q.e_priv;
  assign TCM_RD_VALID_O = s_q.t_valid;
  assign TCM_DISCARD_O = s_q.t_discard;
  assign INSTR_TIGHTMEM_PRIVILEGE_O = s_q.i_priv;
  assign DATA_TIGHTMEM_PRIVILEGE_O = s_q.d_priv;

  // data cache itself (4-way, prefetch) lives outside; this block sees its linefills
  localparam int CACHE_WAYS = 4;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  no_fixed_burst_a: assert property (MAIN_AVALID_O |-> MAIN_ABURST_O != 2'h0)
    else $error("fixed burst issued");
  spec_err_a: assert property (MAIN_ERR_I && MAIN_ERR_SPEC_I |=> !BUS_ERR_O)
    else $error("speculative error reported");
  spec_nofault_a: assert property (take && REQ_SPEC_I |=> !FAULT_O)
    else $error("speculative access faulted");
  viol_block_a: assert property (take && REQ_VIOL_I && REQ_TGT_I == AMP_T_MAIN
      |=> !MAIN_AVALID_O)
    else $error("violating access issued");
  viol_fault_a: assert property (take && REQ_VIOL_I && !REQ_SPEC_I |=> FAULT_O)
    else $error("violation without fault");
  tcm_discard_a: assert property (take && REQ_VIOL_I && REQ_TGT_I == AMP_T_DTCM
      |=> TCM_DISCARD_O)
    else $error("tcm data not discarded");
  ext_nospec_a: assert property (take && REQ_SPEC_I && REQ_TGT_I == AMP_T_EXT_PRIV
      |=> !EXT_PRIV_VALID_O)
    else $error("speculation on external private port");
  xn_nospec_a: assert property (take && REQ_SPEC_I && REQ_XN_I && is_dev(REQ_KIND_I)
      && REQ_TGT_I == AMP_T_MAIN |=> !MAIN_AVALID_O)
    else $error("speculation to device execute-never");
  norm_priv_a: assert property (MAIN_AVALID_O && !MAIN_AWRITE_O
      && (MAIN_AID_O == RID_LINE0 || MAIN_AID_O == RID_LINE1) |-> MAIN_APROT_O[0])
    else $error("normal access not privileged");
  wrap_len_a: assert property (MAIN_AVALID_O && MAIN_ABURST_O == BURST_WRAP
      |-> MAIN_ALEN_O == LEN_4 && MAIN_ASIZE_O == SIZE_B64)
    else $error("bad linefill burst");
  dev_wr_shape_a: assert property (MAIN_AVALID_O && MAIN_AWRITE_O
      && MAIN_AID_O == WID_DEV |-> MAIN_ALEN_O <= 8'h01 && MAIN_ASIZE_O <= SIZE_B32)
    else $error("bad device write burst");
  wr_limit_a: assert property (s_q.wr_dev <= CNT_W'(WR_MAX_DEV)
      && s_q.wr_norm <= CNT_W'(WR_MAX_NORM))
    else $error("write limit exceeded");
  rd_limit_a: assert property (s_q.rd_line <= CNT_W'(RD_MAX_LINE)
      && s_q.rd_nc <= CNT_W'(RD_MAX_NC) && s_q.rd_instr <= CNT_W'(RD_MAX_INSTR))
    else $error("read limit exceeded");
  total_limit_a: assert property (wr_tot + rd_tot <= CNT_W'(TOTAL_MAX))
    else $error("total outstanding exceeded");
  excl_single_a: assert property (MAIN_AVALID_O && MAIN_ALOCK_O
      |-> MAIN_ALEN_O == 8'h00 && MAIN_ASIZE_O <= SIZE_B32)
    else $error("bad exclusive");

  linefill_c: cover property ($rose(MAIN_AVALID_O) && MAIN_ABURST_O == BURST_WRAP);
  fault_c: cover property (FAULT_O);
  tcm_discard_c: cover property (TCM_DISCARD_O && TCM_RD_VALID_O);
  credit_full_c: cover property (s_q.wr_dev == CNT_W'(WR_MAX_DEV));
  spec_block_c: cover property (take && spec_blocked);
endmodule : amp_access_policy

// ---- hw/amp_pkg.sv ----
// package for the main-port access policy block
// assumes a single processor clock and an AXI fabric outside
package amp_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int WR_MAX_TOTAL = 39;
  localparam int WR_MAX_DEV = 15;
  localparam int WR_MAX_NORM = 24;
  localparam int RD_MAX_TOTAL = 5;
  localparam int RD_MAX_LINE = 2;
  localparam int RD_MAX_NC = 2;
  localparam int RD_MAX_INSTR = 1;
  localparam int TOTAL_MAX = 48;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  // axi burst and size encodings
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_WRAP = 2'h2;
  localparam logic [2:0] SIZE_B8 = 3'h0;
  localparam logic [2:0] SIZE_B16 = 3'h1;
  localparam logic [2:0] SIZE_B32 = 3'h2;
  localparam logic [2:0] SIZE_B64 = 3'h3;
  localparam logic [7:0] LEN_4 = 8'h03;
  // write ids
  localparam logic [1:0] WID_DEV = 2'h0;
  localparam logic [1:0] WID_NC = 2'h1;
  localparam logic [1:0] WID_CACHE = 2'h2;
  localparam logic [1:0] WID_EVICT = 2'h3;
  // read ids
  localparam logic [1:0] RID_NCDEV = 2'h0;
  localparam logic [1:0] RID_LINE0 = 2'h1;
  localparam logic [1:0] RID_LINE1 = 2'h2;
  localparam logic [1:0] RID_INSTR = 2'h3;
  // request kinds from the core side
  typedef enum logic [2:0] {
    AMP_K_LINEFILL,
    AMP_K_EVICT,
    AMP_K_NOALLOC_WR,
    AMP_K_IFETCH,
    AMP_K_NC_RD,
    AMP_K_NC_WR,
    AMP_K_DEV_RD,
    AMP_K_DEV_WR
  } amp_kind_t;
  // target interfaces
  typedef enum logic [2:0] {
    AMP_T_MAIN,
    AMP_T_PERIPH,
    AMP_T_EXT_PRIV,
    AMP_T_ITCM,
    AMP_T_DTCM
  } amp_tgt_t;
endpackage : amp_pkg

// ---- testbench/amp_axi_slave_model.sv ----
// partner model: axi slave side of the main port, address and completions
// assumes one clock; completions come back in order on each channel
module amp_axi_slave_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic avalid_i,
  input wire logic awrite_i,
  input wire logic [1:0] aid_i,
  input wire logic hold_i,
  input wire logic slow_i,
  output logic aready_o,
  output logic rdone_o,
  output logic [1:0] rid_o,
  output logic bdone_o,
  output logic [1:0] bid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] rq[$];
  logic [1:0] wq[$];
  logic [1:0] cnt;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rq.delete();
      wq.delete();
      cnt <= 2'h0;
      aready_o <= 1'b0;
      {rdone_o, bdone_o, rid_o, bid_o} <= 6'h0;
    end else begin
      cnt <= cnt + 2'h1;
      // slow mode opens the address channel one cycle in four
      aready_o <= !slow_i || (cnt == 2'h0);
      if (avalid_i && aready_o && awrite_i) wq.push_back(aid_i);
      if (avalid_i && aready_o && !awrite_i) rq.push_back(aid_i);
      rdone_o <= 1'b0;
      bdone_o <= 1'b0;
      // idle id lines toggle so a stale id is never mistaken for a live one
      rid_o <= ~rid_o;
      bid_o <= ~bid_o;
      if (!hold_i && rq.size() > 0) begin
        rdone_o <= 1'b1;
        rid_o <= rq.pop_front();
      end
      if (!hold_i && wq.size() > 0) begin
        bdone_o <= 1'b1;
        bid_o <= wq.pop_front();
      end
    end
  end
endmodule : amp_axi_slave_model

// ---- testbench/axi_master_access_policy_tb.sv ----
// self-checking bench for the main-port access policy block
// assumes the slave model answers the address channel and completions
module axi_master_access_policy_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import amp_pkg::*;
  logic clk = 0, rst = 1, vld = 0, spec = 0, xn = 0, excl = 0, priv = 0, sec = 0;
  logic viol = 0, sel = 0, err = 0, err_spec = 0, hold = 0, slow = 0;
  // rk is the bench's own pick; kind only ever changes at a clock edge
  amp_kind_t kind = AMP_K_LINEFILL, rk;
  amp_tgt_t tgt = AMP_T_MAIN;
  logic [31:0] addr = 32'h0, rnd = 32'h0000_0307;
  logic [2:0] size = 3'h0, asz, aprot;
  logic [1:0] bm = 2'h0, aid, abur, rid, bid;
  logic [7:0] alen;
  logic rdy, fault, av, aw, ar, alock, rdone, bdone, berr, pv, pp, ev, ep, tv, td, ip, dp;
  logic [31:0] aaddr;
  int mismatches = 0, samples_checked = 0, cyc = 0, i, j;
  amp_kind_t ks [8] = '{AMP_K_LINEFILL, AMP_K_LINEFILL, AMP_K_NC_RD, AMP_K_NC_RD,
    AMP_K_IFETCH, AMP_K_LINEFILL, AMP_K_NC_RD, AMP_K_IFETCH};

  amp_access_policy i_dut (.CLK_I(clk), .RST_I(rst), .REQ_VALID_I(vld), .REQ_KIND_I(kind),
    .REQ_TGT_I(tgt), .REQ_ADDR_I(addr), .REQ_SIZE_I(size), .REQ_BEATS_M1_I(bm),
    .REQ_SPEC_I(spec), .REQ_XN_I(xn), .REQ_EXCL_I(excl), .REQ_PRIV_I(priv),
    .REQ_SECURE_I(sec), .REQ_VIOL_I(viol), .REQ_LINE_SEL_I(sel), .REQ_READY_O(rdy),
    .FAULT_O(fault), .MAIN_AVALID_O(av), .MAIN_AWRITE_O(aw), .MAIN_AADDR_O(aaddr),
    .MAIN_AID_O(aid), .MAIN_ALEN_O(alen), .MAIN_ASIZE_O(asz), .MAIN_ABURST_O(abur),
    .MAIN_ALOCK_O(alock), .MAIN_APROT_O(aprot), .MAIN_AREADY_I(ar), .MAIN_RDONE_I(rdone),
    .MAIN_RID_I(rid), .MAIN_BDONE_I(bdone), .MAIN_BID_I(bid), .MAIN_ERR_I(err),
    .MAIN_ERR_SPEC_I(err_spec), .BUS_ERR_O(berr), .PERIPH_VALID_O(pv), .PERIPH_PRIV_O(pp),
    .EXT_PRIV_VALID_O(ev), .EXT_PRIV_PRIV_O(ep), .TCM_RD_VALID_O(tv), .TCM_DISCARD_O(td),
    .INSTR_TIGHTMEM_PRIVILEGE_O(ip), .DATA_TIGHTMEM_PRIVILEGE_O(dp));
  amp_axi_slave_model i_slv (.clk_i(clk), .rst_i(rst), .avalid_i(av), .awrite_i(aw),
    .aid_i(aid), .hold_i(hold), .slow_i(slow), .aready_o(ar), .rdone_o(rdone), .rid_o(rid),
    .bdone_o(bdone), .bid_o(bid));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    // ceiling well above the roughly 200 cycles the sequence needs
    if (cyc > 20000) begin
      mismatches++;
      results();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // {write, id, len, size, burst, prot bit 0} expected on the address channel
  function automatic logic [16:0] exp_a(amp_kind_t k, logic [1:0] b, logic ls, logic p);
    case (k)
      AMP_K_LINEFILL: return {1'b0, ls ? RID_LINE1 : RID_LINE0, LEN_4, SIZE_B64, BURST_WRAP, 1'b1};
      AMP_K_EVICT: return {1'b1, WID_EVICT, LEN_4, SIZE_B64, BURST_INCR, 1'b1};
      AMP_K_NC_RD: return {1'b0, RID_NCDEV, {6'h0, b}, SIZE_B64, BURST_INCR, 1'b1};
      default: return {1'b0, RID_NCDEV, 8'h00, SIZE_B32, BURST_INCR, p};
    endcase
  endfunction : exp_a

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // flags f = {speculative, execute-never, exclusive, violation}
  task automatic go(input amp_kind_t k, input amp_tgt_t t, input logic [2:0] sz,
    input logic [1:0] b, input logic [3:0] f, input logic p, input logic s, input logic ls);
    int n;
    @(posedge clk);
    rnd = xs(rnd);
    kind <= k;
    tgt <= t;
    size <= sz;
    bm <= b;
    {spec, xn, excl, viol} <= f;
    priv <= p;
    sec <= s;
    sel <= ls;
    addr <= {rnd[31:3], 3'h0};
    vld <= 1'b1;
    #1;
    // hold the request until the edge that takes it
    for (n = 0; n < 100 && !(rdy === 1'b1 && !(av === 1'b1 && ar !== 1'b1)); n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask : go

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 50 && rdy !== 1'b1; i++) @(posedge clk);
    // random main-port traffic with a slow slave now and then
    for (i = 0; i < 24; i++) begin
      rnd = xs(rnd);
      slow <= rnd[9];
      j = rnd[1:0];
      rk = (j == 0) ? AMP_K_LINEFILL : (j == 1) ? AMP_K_EVICT : (j == 2) ? AMP_K_NC_RD
        : AMP_K_DEV_RD;
      go(rk, AMP_T_MAIN, (j == 3) ? SIZE_B32 : SIZE_B64, (j == 3) ? 2'h0 : rnd[3:2], 4'h0,
        rnd[4], rnd[5], rnd[6]);
      chk(av, 1);
      chk(aaddr, addr);
      chk({aw, aid, alen, asz, abur, aprot[0]}, exp_a(rk, bm, sel, priv));
      // axi prot bit 1 set means non-secure
      chk(aprot[1], !sec);
    end
    slow <= 1'b0;
    for (i = 0; i < 2; i++) begin
      go(AMP_K_NC_RD, AMP_T_PERIPH, SIZE_B32, 2'h0, 4'h0, i[0], 1'b0, 1'b0);
      chk({pv, pp}, {1'b1, i[0]});
      go(AMP_K_DEV_RD, AMP_T_EXT_PRIV, SIZE_B32, 2'h0, 4'h0, i[0], 1'b0, 1'b0);
      chk({ev, ep}, {1'b1, i[0]});
      go(AMP_K_IFETCH, AMP_T_ITCM, SIZE_B64, 2'h0, 4'h0, i[0], 1'b0, 1'b0);
      chk(ip, i[0]);
      go(AMP_K_NC_RD, AMP_T_DTCM, SIZE_B32, 2'h0, 4'h0, i[0], 1'b0, 1'b0);
      chk(dp, i[0]);
      @(posedge clk);
      err <= 1'b1;
      err_spec <= i[0];
      @(posedge clk);
      err <= 1'b0;
      #1;
      chk(berr, !i[0]);
    end
    go(AMP_K_DEV_RD, AMP_T_MAIN, SIZE_B32, 2'h0, 4'hc, 1'b1, 1'b0, 1'b0);
    chk(av, 0);
    go(AMP_K_DEV_RD, AMP_T_EXT_PRIV, SIZE_B32, 2'h0, 4'h8, 1'b1, 1'b0, 1'b0);
    chk(ev, 0);
    go(AMP_K_NC_RD, AMP_T_DTCM, SIZE_B32, 2'h0, 4'h8, 1'b1, 1'b0, 1'b0);
    chk(tv, 1);
    go(AMP_K_LINEFILL, AMP_T_MAIN, SIZE_B64, 2'h3, 4'h1, 1'b1, 1'b0, 1'b0);
    chk({fault, av}, 2'b10);
    go(AMP_K_NC_RD, AMP_T_PERIPH, SIZE_B32, 2'h0, 4'h1, 1'b1, 1'b0, 1'b0);
    chk({fault, pv}, 2'b10);
    go(AMP_K_NC_RD, AMP_T_DTCM, SIZE_B32, 2'h0, 4'h1, 1'b1, 1'b0, 1'b0);
    chk({fault, td}, 2'b11);
    go(AMP_K_LINEFILL, AMP_T_MAIN, SIZE_B64, 2'h3, 4'h9, 1'b1, 1'b0, 1'b0);
    chk(fault, 0);
    go(AMP_K_NC_WR, AMP_T_MAIN, SIZE_B32, 2'h0, 4'h2, 1'b1, 1'b0, 1'b0);
    chk({av, alock, aid}, {2'b11, WID_NC});
    go(AMP_K_NC_WR, AMP_T_MAIN, SIZE_B64, 2'h0, 4'h2, 1'b1, 1'b0, 1'b0);
    chk(av, 0);
    // hold completions so credits run out, then drain
    hold <= 1'b1;
    for (i = 0; i < 16; i++) begin
      go(AMP_K_DEV_WR, AMP_T_MAIN, SIZE_B32, 2'h0, 4'h0, 1'b1, 1'b0, 1'b0);
      chk({av, aid}, {i < 15, WID_DEV});
    end
    for (i = 0; i < 8; i++) begin
      go(ks[i], AMP_T_MAIN, SIZE_B64, 2'h0, 4'h0, 1'b1, 1'b0, i[0]);
      chk(av, i < 5);
    end
    hold <= 1'b0;
    repeat (30) @(posedge clk);
    go(AMP_K_LINEFILL, AMP_T_MAIN, SIZE_B64, 2'h3, 4'h0, 1'b1, 1'b0, 1'b1);
    chk({av, aid}, {1'b1, RID_LINE1});
    results();
  end
endmodule : axi_master_access_policy_tb
